// >>> logic/wdm_pkg.sv
// Package for the watchdog event manager: register map, field positions,
// reset values, timing constants and the reset request carrier.
// Assumes a 25 MHz system clock and a 32-bit classic Wishbone register bus.
package wdm_pkg;

  // Timing: one millisecond base tick
  localparam int unsigned CLK_PERIOD_NS = 40;          // 25 MHz clock
  localparam int unsigned MS_TIME_NS    = 1000000;     // 1.0 ms base unit
  localparam int unsigned MS_CYCLES     = (MS_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Register byte offsets
  localparam logic [7:0] OFS_CTRL   = 8'h00;  // Enables and pin reset type
  localparam logic [7:0] OFS_CFG    = 8'h04;  // Window duration, max expiry
  localparam logic [7:0] OFS_STATUS = 8'h08;  // Refresh flag, counters
  localparam logic [7:0] OFS_MAXEVT = 8'h0c;  // Maximum event setting
  localparam logic [7:0] OFS_KEY    = 8'h10;  // Secure write unlock

  // Field positions
  localparam int unsigned CTRL_EN_BIT    = 0;  // timer_enable_bit
  localparam int unsigned CTRL_STBY_BIT  = 1;  // standby_timer_enable_bit
  localparam int unsigned CTRL_PSEL_BIT  = 2;  // pin_event_reset_type_sel
  localparam int unsigned CTRL_WMODE_BIT = 3;  // window mode, read only
  localparam int unsigned CFG_DUR_LSB    = 0;  // window_duration_sel [3:0]
  localparam int unsigned CFG_MAXX_LSB   = 4;  // max_expiry_setting [6:4]
  localparam int unsigned ST_FLAG_BIT    = 0;  // refresh_pending_flag, W1C
  localparam int unsigned ST_EXP_LSB     = 4;  // expiry_counter [6:4]
  localparam int unsigned ST_EVT_LSB     = 8;  // event_counter [11:8]
  localparam int unsigned ST_EVTCLR_BIT  = 12; // Write 1 clears event_counter

  // Secure write key and reset values
  localparam logic [7:0]  SECURE_KEY     = 8'ha5;
  localparam logic [2:0]  EXP_MAX        = 3'h7;
  localparam logic [3:0]  EVT_MAX        = 4'hf;
  localparam logic [15:0] CNT_RST        = 16'h0000;

  // Reset request towards the reset sequencer
  typedef struct packed {
    logic req;   // One-cycle request
    logic hard;  // 1 = hard reset, 0 = soft reset
  } wdm_rst_req_t;

endpackage

// >>> logic/wdm_tick_gen.sv
// Millisecond tick generator for the watchdog window timer.
// Assumes one clock; clear_i restarts the prescaler so a fresh window
// always starts on a whole millisecond boundary.
`timescale 1ns/10ps
module wdm_tick_gen #(
  parameter int unsigned CYCLES = 25000
) (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic clear_i,
  output logic      tick_o
);

  initial begin
    if (CYCLES < 2 || CYCLES > 65536) begin
      $error("wdm_tick_gen: CYCLES out of range");
    end
  end

  logic [15:0] pre_q, pre_d;  // Prescaler count
  logic        tick_d;        // Next tick value, registered into tick_o

  // Next state: wrap at CYCLES-1 and pulse once
  always_comb begin
    pre_d  = pre_q + 16'h0001;
    tick_d = 1'b0;
    if (clear_i) begin
      pre_d = 16'h0000;
    end else if (pre_q == 16'(CYCLES - 1)) begin
      pre_d  = 16'h0000;
      tick_d = 1'b1;
    end
  end

  // Registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pre_q  <= 16'h0000;
      tick_o <= 1'b0;
    end else begin
      pre_q  <= pre_d;
      tick_o <= tick_d;
    end
  end

endmodule

// >>> logic/wdm_event_manager.sv
// Watchdog event manager: window timer, expiry and event counters, pin
// event detection and reset request generation, behind a Wishbone slave.
// Assumes one 25 MHz clock, the sequencer's host reset level and off /
// standby state levels on the same clock, and an asynchronous pin input.
`timescale 1ns/10ps
module wdm_event_manager
  import wdm_pkg::*;
#(
  parameter int unsigned MS_CYC = MS_CYCLES  // Cycles per millisecond
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Classic Wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  // System state
  input  wire logic        off_state_i,            // Device in an off state
  input  wire logic        standby_i,              // Device in standby
  input  wire logic        host_reset_out_n_i,     // High when host reset released
  input  wire logic        secure_mode_i,          // Secure writes required
  input  wire logic        ext_watchdog_input_pin_i,
  // One-time-programmable defaults
  input  wire logic [3:0]  otp_window_duration_default_i,
  input  wire logic [2:0]  otp_max_expiry_default_i,
  input  wire logic        otp_window_mode_cfg_i,
  input  wire logic        otp_timer_enable_i,
  input  wire logic        otp_standby_timer_enable_i,
  input  wire logic [3:0]  otp_max_event_default_i,
  // Requests to the reset sequencer
  output wdm_rst_req_t     rst_req_o,
  output logic             fail_safe_o
);

  initial begin
    if (MS_CYC < 2 || MS_CYC > 65536) begin
      $error("wdm_event_manager: MS_CYC out of range");
    end
  end

  // Configuration and state registers
  logic        en_q, en_d;            // timer_enable_bit
  logic        stby_en_q, stby_en_d;  // standby_timer_enable_bit
  logic        psel_q, psel_d;        // pin_event_reset_type_sel, 1 = hard
  logic        wmode_q, wmode_d;      // Window mode from OTP
  logic [3:0]  dur_q, dur_d;          // window_duration_sel
  logic [2:0]  maxx_q, maxx_d;        // max_expiry_setting
  logic [3:0]  maxe_q, maxe_d;        // max_event_setting
  logic        flag_q, flag_d;        // refresh_pending_flag
  logic [2:0]  exp_q, exp_d;          // expiry_counter
  logic [3:0]  evt_q, evt_d;          // event_counter
  logic [15:0] cnt_q, cnt_d;          // Window timer in ms
  logic        armed_q, armed_d;      // Timer allowed after host reset release
  logic        unlk_q, unlk_d;        // Secure write unlocked until the next control write
  logic        ack_d;
  logic [31:0] rdat_d;
  wdm_rst_req_t req_d;
  logic        fs_d;
  // Pin synchroniser, second stage and edge history
  logic        pin_s1_q, pin_s2_q, pin_s3_q;

  logic        tick;      // Millisecond tick
  logic        restart;   // Timer restarts this cycle
  logic        bus_wr;    // Write accepted this cycle
  logic        run;       // Timer may count
  logic        pin_fall;  // Synchronised falling edge of the pin
  logic        clr_req, good_clr, bad_clr, expire, dur_chg, int_evt;
  logic [15:0] limit;

  // Duration decode: two to the field value, in ms
  function automatic logic [15:0] dur_limit(input logic [3:0] sel);
    dur_limit = 16'h0001 << sel;
  endfunction

  // Byte lane merge for register writes
  function automatic logic [31:0] lane_mask(input logic [3:0] sel);
    lane_mask = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
  endfunction

  wdm_tick_gen #(
    .CYCLES (MS_CYC)
  ) u_tick (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .clear_i (restart),
    .tick_o  (tick)
  );

  // Pin synchroniser: stage one feeds stage two only
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_s1_q <= 1'b1;
      pin_s2_q <= 1'b1;
      pin_s3_q <= 1'b1;
    end else begin
      pin_s1_q <= ext_watchdog_input_pin_i;
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
    end
  end

  // A write commits in the cycle the ack is raised, so once per request
  assign bus_wr   = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o;
  assign pin_fall = pin_s3_q && !pin_s2_q && !off_state_i;
  assign limit    = dur_limit(dur_q);
  // Enable, standby enable and host reset release gate the timer
  assign run      = armed_q && en_q && (!standby_i || stby_en_q) && !off_state_i;
  // Host clear of the flag: write one to its bit while it is set
  assign clr_req  = bus_wr && (wb_adr_i == OFS_STATUS) && wb_sel_i[0] && wb_dat_i[ST_FLAG_BIT] && flag_q;
  // Whole period valid, or second half only in window mode
  assign good_clr = run && clr_req && (!wmode_q || cnt_q >= (limit >> 1));
  assign bad_clr  = run && clr_req && !good_clr;
  assign expire   = run && tick && !clr_req && (cnt_q + 16'h0001 == limit);
  assign dur_chg  = bus_wr && (wb_adr_i == OFS_CFG) && wb_sel_i[0]
                    && (wb_dat_i[CFG_DUR_LSB +: 4] != dur_q);

  // Main next-state logic: bus, timer, counters and requests
  always_comb begin
    logic [31:0] wmask;
    logic [3:0]  xsum;
    wmask     = lane_mask(wb_sel_i);
    xsum      = 4'h0;
    en_d      = en_q;
    stby_en_d = stby_en_q;
    psel_d    = psel_q;
    wmode_d   = wmode_q;
    dur_d     = dur_q;
    maxx_d    = maxx_q;
    maxe_d    = maxe_q;
    flag_d    = flag_q;
    exp_d     = exp_q;
    evt_d     = evt_q;
    cnt_d     = cnt_q;
    armed_d   = armed_q;
    unlk_d    = unlk_q;
    restart   = 1'b0;
    int_evt   = 1'b0;
    req_d     = '0;
    fs_d      = 1'b0;
    ack_d     = wb_cyc_i && wb_stb_i && !wb_ack_o;
    rdat_d    = 32'h0000_0000;

    // Register reads, unmapped reads as zero
    if (wb_adr_i == OFS_CTRL) begin
      rdat_d = {28'h0, wmode_q, psel_q, stby_en_q, en_q};
    end else if (wb_adr_i == OFS_CFG) begin
      rdat_d = {25'h0, maxx_q, dur_q};
    end else if (wb_adr_i == OFS_STATUS) begin
      rdat_d = {20'h0, evt_q, 1'b0, exp_q, 3'h0, flag_q};
    end else if (wb_adr_i == OFS_MAXEVT) begin
      rdat_d = {28'h0, maxe_q};
    end

    // Register writes
    if (bus_wr) begin
      if (wb_adr_i == OFS_CTRL && wmask[0]) begin
        // Enables need an unlock first in secure mode
        if (!secure_mode_i || unlk_q) begin
          en_d      = wb_dat_i[CTRL_EN_BIT];
          stby_en_d = wb_dat_i[CTRL_STBY_BIT];
        end
        psel_d = wb_dat_i[CTRL_PSEL_BIT];
        unlk_d = 1'b0;
      end else if (wb_adr_i == OFS_CFG && wmask[0]) begin
        dur_d  = wb_dat_i[CFG_DUR_LSB +: 4];
        maxx_d = wb_dat_i[CFG_MAXX_LSB +: 3];
      end else if (wb_adr_i == OFS_STATUS && wmask[8] && wb_dat_i[ST_EVTCLR_BIT]) begin
        evt_d = 4'h0;
      end else if (wb_adr_i == OFS_MAXEVT && wmask[0]) begin
        maxe_d = wb_dat_i[3:0];
      end else if (wb_adr_i == OFS_KEY && wmask[0]) begin
        unlk_d = (wb_dat_i[7:0] == SECURE_KEY);
      end
    end

    // Host reset release lets the timer start after power-up
    if (host_reset_out_n_i && !armed_q) begin
      armed_d = 1'b1;
      restart = 1'b1;
    end

    // Window timer advance
    if (run && tick) begin
      cnt_d = cnt_q + 16'h0001;
    end
    // Duration write with a new value restarts the window
    if (dur_chg && !off_state_i) begin
      restart = 1'b1;
    end
    // Good refresh: step expiry down, saturating at zero
    if (good_clr) begin
      restart = 1'b1;
      if (exp_q != 3'h0) begin
        exp_d = exp_q - 3'h1;
      end
    end
    // Miss or early clear: step expiry up by two, saturating
    if (expire || bad_clr) begin
      restart = 1'b1;
      xsum    = {1'b0, exp_q} + 4'h2;
      exp_d   = (xsum > {1'b0, EXP_MAX}) ? EXP_MAX : xsum[2:0];
      // Limit reached; at two or below the first miss already gets there
      if ((xsum[2:0] == maxx_q && !xsum[3]) || maxx_q <= 3'h2 || exp_d == maxx_q) begin
        int_evt = 1'b1;
      end
    end
    // Every restart outside the off states opens a new window with the flag pending
    if (restart) begin
      cnt_d  = CNT_RST;
      flag_d = 1'b1;
    end else if (clr_req) begin
      flag_d = 1'b0;
    end

    // Watchdog event: pin type from select, timer always hard
    if (int_evt || pin_fall) begin
      req_d.req  = 1'b1;
      req_d.hard = int_evt ? 1'b1 : psel_q;
      exp_d      = 3'h0;
      if (evt_q != EVT_MAX) begin
        evt_d = evt_q + 4'h1;
      end
      fs_d = (evt_d == maxe_q);
    end

    // Off states: clear timer and events, reload defaults
    if (off_state_i) begin
      cnt_d     = CNT_RST;
      evt_d     = 4'h0;
      exp_d     = 3'h0;
      armed_d   = 1'b0;
      flag_d    = 1'b0;
      dur_d     = otp_window_duration_default_i;
      maxx_d    = otp_max_expiry_default_i;
      maxe_d    = otp_max_event_default_i;
      wmode_d   = otp_window_mode_cfg_i;
      en_d      = otp_timer_enable_i;
      stby_en_d = otp_standby_timer_enable_i;
      req_d     = '0;
      fs_d      = 1'b0;
    end
  end

  // State registers; reset loads the programmable defaults
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      en_q        <= otp_timer_enable_i;
      stby_en_q   <= otp_standby_timer_enable_i;
      psel_q      <= 1'b0;
      wmode_q     <= otp_window_mode_cfg_i;
      dur_q       <= otp_window_duration_default_i;
      maxx_q      <= otp_max_expiry_default_i;
      maxe_q      <= otp_max_event_default_i;
      flag_q      <= 1'b0;
      exp_q       <= 3'h0;
      evt_q       <= 4'h0;
      cnt_q       <= CNT_RST;
      armed_q     <= 1'b0;
      unlk_q      <= 1'b0;
      wb_ack_o    <= 1'b0;
      wb_dat_o    <= 32'h0000_0000;
      rst_req_o   <= '0;
      fail_safe_o <= 1'b0;
    end else begin
      en_q        <= en_d;
      stby_en_q   <= stby_en_d;
      psel_q      <= psel_d;
      wmode_q     <= wmode_d;
      dur_q       <= dur_d;
      maxx_q      <= maxx_d;
      maxe_q      <= maxe_d;
      flag_q      <= flag_d;
      exp_q       <= exp_d;
      evt_q       <= evt_d;
      cnt_q       <= cnt_d;
      armed_q     <= armed_d;
      unlk_q      <= unlk_d;
      wb_ack_o    <= ack_d;
      wb_dat_o    <= rdat_d;
      rst_req_o   <= req_d;
      fail_safe_o <= fs_d;
    end
  end

  // Checks on the block's own outputs and state
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_pin_type_sel: assert property (pin_fall |=> rst_req_o.req && rst_req_o.hard == $past(psel_q))
    else $error("pin event reset type wrong");
  a_timer_hard: assert property (int_evt && !off_state_i |=> rst_req_o.req && rst_req_o.hard)
    else $error("timer event not hard");
  a_single_req: assert property (rst_req_o.req && !$past(pin_fall) |=> !rst_req_o.req)
    else $error("request longer than one cycle");
  a_restart_flag: assert property (restart && !off_state_i |=> flag_q && cnt_q == 16'h0000)
    else $error("restart without pending flag");
  a_good_dec: assert property (good_clr && !int_evt && !pin_fall && !off_state_i && exp_q != 3'h0
                               |=> exp_q == $past(exp_q) - 3'h1)
    else $error("good refresh did not decrement");
  a_miss_inc: assert property (expire && !int_evt && !pin_fall && !off_state_i
                               |=> exp_q == (($past(exp_q) > 3'h5) ? EXP_MAX : $past(exp_q) + 3'h2))
    else $error("miss did not add two");
  a_off_clear: assert property (off_state_i |=> cnt_q == 16'h0000 && evt_q == 4'h0 && !armed_q)
    else $error("off state did not clear");
  a_early_fail: assert property (run && clr_req && wmode_q && cnt_q < (limit >> 1) |-> bad_clr)
    else $error("early clear accepted");
  a_idle_hold: assert property (!run && !restart |=> cnt_q == $past(cnt_q) || off_state_i)
    else $error("timer moved while stopped");

  c_good_refresh: cover property (good_clr);
  c_timer_event:  cover property (int_evt ##1 rst_req_o.req);
  c_pin_event:    cover property (pin_fall ##1 rst_req_o.req);
  c_fail_safe:    cover property (fail_safe_o);

endmodule

// >>> testbench/wdm_host_model.sv
// Host model: a classic Wishbone master and the driver of the watchdog pin.
// Assumes it shares the device clock; the bench calls its tasks in turn.
`timescale 1ns/10ps
module wdm_host_model
  import wdm_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        wb_ack_i,
  input  wire logic [31:0] wb_dat_i,
  output logic             wb_cyc_o,
  output logic             wb_stb_o,
  output logic             wb_we_o,
  output logic [7:0]       wb_adr_o,
  output logic [3:0]       wb_sel_o,
  output logic [31:0]      wb_dat_o,
  output logic             pin_o
);
  // Idle bus, pin held high as by its pull-up
  initial begin
    wb_cyc_o = 1'b0;
    wb_stb_o = 1'b0;
    wb_we_o  = 1'b0;
    wb_adr_o = 8'h00;
    wb_sel_o = 4'h0;
    wb_dat_o = 32'h0;
    pin_o    = 1'b1;
  end

  // One classic cycle; held until the edge that samples ack, no cycle count assumed
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge clk_i);
    wb_cyc_o <= 1'b1;
    wb_stb_o <= 1'b1;
    wb_we_o  <= w;
    wb_adr_o <= a;
    wb_sel_o <= 4'hf;
    wb_dat_o <= d;
    do @(posedge clk_i); while (wb_ack_i !== 1'b1);
    q = wb_dat_i;
    wb_cyc_o <= 1'b0;
    wb_stb_o <= 1'b0;
    wb_we_o  <= 1'b0;
    wb_dat_o <= ~d;  // Released data must not look valid
  endtask

  // Refresh: write one to the pending flag to clear it
  task automatic refresh();
    logic [31:0] q;
    xfer(1'b1, OFS_STATUS, 32'h1, q);
  endtask

  // Pull the watchdog pin low for n cycles
  task automatic pulse(input int n);
    @(posedge clk_i);
    pin_o <= 1'b0;
    repeat (n) @(posedge clk_i);
    pin_o <= 1'b1;
  endtask
endmodule

// >>> testbench/wdm_tb_top.sv
// Self-checking bench for the watchdog event manager with a short ms tick.
// Assumes the host model drives the bus and pin; integers model the counters.
`timescale 1ns/10ps
module pmic_watchdog_event_manager_tb_top;
  import wdm_pkg::*;
  localparam int unsigned MSC = 4;  // Window = 4 * 2^dur cycles, keeps run short
  logic         clk_i, rst_i, off_i, stby_i, hrel_i, sec_i, wm_i, ack, fs;
  logic [2:0]   mx_i;
  logic [3:0]   dur_i, mev_i;     // Programmable defaults driven by the bench
  logic         oen_i;
  logic         cyc, stb, we, pin;
  logic [7:0]   adr;
  logic [3:0]   sel;
  logic [31:0]  wdat, rdat, v;
  wdm_rst_req_t rq;
  int           n_mismatch, total_checks, n_fs, exp_q, max_m, ev_n;
  logic         hq[$];            // Reset types seen, in order
  logic [31:0]  rs = 32'd42;      // Xorshift state

  wdm_event_manager #(.MS_CYC(MSC)) dut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .off_state_i(off_i),
    .standby_i(stby_i), .host_reset_out_n_i(hrel_i), .secure_mode_i(sec_i),
    .ext_watchdog_input_pin_i(pin), .otp_window_duration_default_i(dur_i),
    .otp_max_expiry_default_i(mx_i), .otp_window_mode_cfg_i(wm_i), .otp_timer_enable_i(oen_i),
    .otp_standby_timer_enable_i(1'b0), .otp_max_event_default_i(mev_i), .rst_req_o(rq), .fail_safe_o(fs));

  wdm_host_model host (
    .clk_i(clk_i), .wb_ack_i(ack), .wb_dat_i(rdat), .wb_cyc_o(cyc), .wb_stb_o(stb), .wb_we_o(we),
    .wb_adr_o(adr), .wb_sel_o(sel), .wb_dat_o(wdat), .pin_o(pin));

  // Clock, 40 ns period
  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end

  // Collect one-cycle requests and fail-safe pulses mid-cycle, clear of the edge race
  always @(negedge clk_i) begin
    if (rq.req === 1'b1) begin
      hq.push_back(rq.hard);
    end
    if (fs === 1'b1) begin
      n_fs++;
    end
  end

  function automatic logic [31:0] xs();
    rs ^= rs << 13;
    rs ^= rs >> 17;
    rs ^= rs << 5;
    return rs;
  endfunction

  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic chk_val(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Oldest request must carry the expected reset type
  task automatic chk_evt(input logic e);
    logic g;
    g = 1'bx;
    if (hq.size() > 0) begin
      g = hq.pop_front();
    end
    chk_val("reset type", {31'h0, e}, {31'h0, g});
  endtask

  task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    host.xfer(1'b0, a, 32'h0, v);
    chk_val(nm, e, v & m);
  endtask

  task automatic chk_exp();
    rdc("expiry", OFS_STATUS, 32'h70, 32'(exp_q) << 4);
  endtask

  // Model: miss adds two with saturation; limit or small maximum fires an event
  task automatic miss();
    exp_q = (exp_q + 2 > 7) ? 7 : exp_q + 2;
    if (exp_q == max_m || max_m <= 2) begin
      exp_q = 0;
      ev_n++;
    end
  endtask

  task automatic good();
    exp_q = (exp_q > 0) ? exp_q - 1 : 0;
  endtask

  task automatic w(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  task automatic do_reset();
    rst_i <= 1'b1;
    w(2);
    rst_i <= 1'b0;
    exp_q = 0;
    ev_n = 0;
  endtask

  // Hang guard: whole sequence needs well under 2000 cycles
  initial begin
    w(4000);
    n_mismatch++;
    close_out();
  end

  initial begin
    rst_i = 1'b1;
    {off_i, stby_i, sec_i, wm_i} = 4'h0;
    hrel_i = 1'b1;
    mx_i = 3'h5;
    dur_i = 4'h3;
    mev_i = 4'h3;
    oen_i = 1'b1;
    max_m = 5;
    {n_mismatch, total_checks, n_fs, ev_n} = '0;
    do_reset();
    rdc("ctrl", OFS_CTRL, 32'hb, 32'h1);
    rdc("cfg", OFS_CFG, 32'h7f, 32'h53);
    rdc("max event", OFS_MAXEVT, 32'hf, 32'h3);
    host.xfer(1'b1, 8'h14, xs(), v);
    rdc("unmapped", 8'h14, 32'hffffffff, 32'h0);
    rdc("flag", OFS_STATUS, 32'h1, 32'h1);
    host.refresh();
    good();
    chk_exp();
    w(20);
    chk_exp();
    w(17);
    miss();
    chk_exp();
    rdc("flag", OFS_STATUS, 32'h1, 32'h1);
    w(xs() % 8);
    host.refresh();
    good();
    chk_exp();
    w(140);
    repeat (4) miss();
    chk_exp();
    chk_evt(1'b1);
    chk_val("pending", 32'h0, hq.size());
    // Window mode: early clears count as misses
    wm_i <= 1'b1;
    do_reset();
    host.refresh();
    miss();
    chk_exp();
    w(20);
    host.refresh();
    good();
    chk_exp();
    host.refresh();
    miss();
    host.refresh();
    miss();
    chk_evt(1'b1);
    chk_exp();
    host.xfer(1'b1, OFS_CFG, 32'h13, v);
    max_m = 1;
    w(40);
    miss();
    chk_evt(1'b1);
    // Pin events with the timer stopped
    host.xfer(1'b1, OFS_CTRL, 32'h0, v);
    host.pulse(4);
    w(6);
    ev_n++;
    chk_evt(1'b0);
    host.xfer(1'b1, OFS_CTRL, 32'h4, v);
    host.pulse(4);
    w(6);
    ev_n++;
    chk_evt(1'b1);
    chk_val("fail safe", 32'h1, n_fs);
    rdc("event count", OFS_STATUS, 32'hf00, 32'(ev_n) << 8);
    // Standby without its enable, then enable through the secure key
    stby_i <= 1'b1;
    sec_i <= 1'b1;
    host.xfer(1'b1, OFS_CTRL, 32'h1, v);
    rdc("locked", OFS_CTRL, 32'h1, 32'h0);
    host.xfer(1'b1, OFS_KEY, 32'ha5, v);
    host.xfer(1'b1, OFS_CTRL, 32'h1, v);
    rdc("unlocked", OFS_CTRL, 32'h1, 32'h1);
    sec_i <= 1'b0;
    w(80);
    chk_val("pending", 32'h0, hq.size());
    // Off state clears counters; timer waits for host reset release
    off_i <= 1'b1;
    hrel_i <= 1'b0;
    stby_i <= 1'b0;
    w(3);
    off_i <= 1'b0;
    max_m = 5;
    rdc("event count", OFS_STATUS, 32'hf00, 32'h0);
    w(80);
    chk_exp();
    chk_val("pending", 32'h0, hq.size());
    hrel_i <= 1'b1;
    w(40);
    miss();
    chk_exp();
    // A new duration mid-window restarts it, so no miss lands before the read
    host.xfer(1'b1, OFS_CFG, 32'h52, v);
    w(6);
    chk_exp();
    close_out();
  end
endmodule
